//--- logic/vout_fault_response_logic.sv
// Fault response for one output rail: overvoltage and undervoltage handling.
// Assumes comparator and pin levels are asynchronous; command strobes, the sequencer
// flags, the retry interval and the overcurrent flag come from logic on mclk.

module vout_fault_response_logic
    import vout_fault_pkg::*;
(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic cfgWrite,
    input wire logic cfgSelUv,
    input wire logic [7:0] cfgData,
    input wire logic clearFaults,
    input wire logic softResetCmd,
    input wire logic operationOn,
    input wire logic channel_run_pin,
    input wire logic bias_input_supply,
    input wire logic ovDetect,
    input wire logic uvDetect,
    input wire logic decayBelowEighth,
    input wire logic ocFault,
    input wire seq_status_s seq,
    input wire logic [RETRY_W-1:0] vendor_retry_interval_cmd,
    input wire logic noDecayWait,
    input wire logic alertMaskOv,
    input wire logic alertMaskUv,
    output logic outputEnable,
    output logic pullDownActive,
    output fault_status_s faultStatus,
    output logic alertN,
    output logic [7:0] ovResponse,
    output logic [7:0] uvResponse
);

    // ************************************************************
    // Declarations
    // ************************************************************
    typedef enum logic [1:0] {ST_OFF, ST_RUN, ST_RETRY, ST_LATCHED} chan_state_e;
    chan_state_e state, next_state;
    logic keepClear, next_keepClear;
    logic [4:0] pinLevels;
    logic runPin, biasGood, ovFault, uvRaw, decayLow, runOn, runOnPrev, runRise, biasPrev, biasFall;
    logic [PRESCALE_W-1:0] prescale, next_prescale;
    logic tick, next_tick, ovHoldDone, uvHoldDone, retryHoldDone, retryDone, uvArmed, next_uvArmed;
    logic uvMasked, uvFault, ovTrip, uvTrip, tripRetry, tripClearable, ovLatchesDuringRetry, goOff;
    logic [7:0] next_ovResponse, next_uvResponse;
    fault_status_s next_faultStatus;
    logic statusClear, next_outputEnable, next_pullDownActive, next_alertN;

    // ************************************************************
    // Inputs and time base
    // ************************************************************
    // Pins from outside the clock domain
    pin_sync #(.WIDTH(5)) u_pins (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .pins({channel_run_pin, bias_input_supply, ovDetect, uvDetect, decayBelowEighth}),
        .synced(pinLevels)
    );

    assign runPin = pinLevels[4];
    assign biasGood = pinLevels[3];
    assign ovFault = pinLevels[2];
    assign uvRaw = pinLevels[1];
    assign decayLow = pinLevels[0];

    // Channel is commanded on only with run pin, operation and bias all present
    assign runOn = runPin && operationOn && biasGood;
    assign runRise = runOn && !runOnPrev;
    assign biasFall = biasPrev && !biasGood;
    assign goOff = !runOn || softResetCmd;

    // Ten microsecond tick divider
    always_comb begin
        next_prescale = prescale + PRESCALE_W'(1);
        next_tick = 1'b0;
        if (prescale == PRESCALE_LAST) begin
            next_prescale = '0;
            next_tick = 1'b1;
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            prescale <= '0;
            tick <= 1'b0;
            runOnPrev <= 1'b0;
            biasPrev <= 1'b0;
        end else begin
            prescale <= next_prescale;
            tick <= next_tick;
            runOnPrev <= runOn;
            biasPrev <= biasGood;
        end
    end

    // ************************************************************
    // Response byte writes
    // ************************************************************
    // Refused bytes leave the stored value untouched
    always_comb begin
        next_ovResponse = ovResponse;
        next_uvResponse = uvResponse;
        if (cfgWrite && respValid(cfgSelUv, cfgData)) begin
            if (cfgSelUv) begin
                next_uvResponse = cfgData;
            end else begin
                next_ovResponse = cfgData;
            end
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            ovResponse <= OV_RESP_RESET;
            uvResponse <= UV_RESP_RESET;
        end else begin
            ovResponse <= next_ovResponse;
            uvResponse <= next_uvResponse;
        end
    end

    // ************************************************************
    // Undervoltage masking
    // ************************************************************
    // Armed once every start criterion is met; disarmed whenever the rail is off
    always_comb begin
        next_uvArmed = outputEnable && (uvArmed || (seq.tonMaxReached && seq.tonDelayDone &&
                       seq.tonRiseDone && seq.uvLevelReached && !ocFault));
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            uvArmed <= 1'b0;
        end else begin
            uvArmed <= next_uvArmed;
        end
    end

    assign uvMasked = !uvArmed || !outputEnable || !seq.tonRiseDone || seq.toffFalling;
    assign uvFault = uvRaw && !uvMasked;

    // ************************************************************
    // Delay timers
    // ************************************************************
    // Hold timers restart when the fault drops, so a short glitch cancels the shutdown
    hold_timer #(.W(DELAY_W)) u_ov_hold (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .tick(tick),
        .run(ovFault && (state == ST_RUN)),
        .target(delayOf(ovResponse)),
        .done(ovHoldDone)
    );

    hold_timer #(.W(DELAY_W)) u_uv_hold (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .tick(tick),
        .run(uvFault && (state == ST_RUN)),
        .target(delayOf(uvResponse)),
        .done(uvHoldDone)
    );

    hold_timer #(.W(RETRY_W)) u_retry (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .tick(tick),
        .run(state == ST_RETRY),
        .target(vendor_retry_interval_cmd),
        .done(retryHoldDone)
    );

    // Restart needs the interval and, unless waived, the output decayed
    assign retryDone = retryHoldDone && (decayLow || noDecayWait);

    // ************************************************************
    // Shutdown decision
    // ************************************************************
    // Field 10 acts at once, field 01 after the hold; field 00 never disables
    assign ovTrip = ovFault && ((respField(ovResponse) == RESP_SHUT) ||
                    ((respField(ovResponse) == RESP_CONTINUE) && ovHoldDone));
    assign uvTrip = uvFault && ((respField(uvResponse) == RESP_SHUT) ||
                    ((respField(uvResponse) == RESP_CONTINUE) && uvHoldDone));
    // Any tripping source without endless retry wins and latches
    assign tripRetry = (!ovTrip || retriesForever(ovResponse)) &&
                       (!uvTrip || retriesForever(uvResponse));
    // Immediate no-retry shutdowns may be released by a clear command
    assign tripClearable = (!ovTrip || respField(ovResponse) == RESP_SHUT) &&
                           (!uvTrip || respField(uvResponse) == RESP_SHUT);
    // An immediate overvoltage that must not retry ends a retry series
    assign ovLatchesDuringRetry = ovFault && (respField(ovResponse) == RESP_SHUT) &&
                                  !retriesForever(ovResponse);

    // ************************************************************
    // Channel state
    // ************************************************************
    // Off-then-on, run toggle, reset command and supply loss all pass through ST_OFF
    always_comb begin
        next_state = state;
        next_keepClear = keepClear;
        unique case (state)
            ST_OFF: begin
                if (!goOff) begin
                    next_state = ST_RUN;
                end
            end
            ST_RUN: begin
                if (goOff) begin
                    next_state = ST_OFF;
                end else if (ovTrip || uvTrip) begin
                    next_state = tripRetry ? ST_RETRY : ST_LATCHED;
                    next_keepClear = tripClearable;
                end
            end
            ST_RETRY: begin
                if (goOff) begin
                    next_state = ST_OFF;
                end else if (ovLatchesDuringRetry) begin
                    next_state = ST_LATCHED;
                    next_keepClear = 1'b1;
                end else if (retryDone) begin
                    next_state = ST_RUN;
                end
            end
            ST_LATCHED: begin
                if (goOff) begin
                    next_state = ST_OFF;
                end else if (clearFaults && keepClear) begin
                    next_state = ST_RUN;
                end
            end
        endcase
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            state <= ST_OFF;
            keepClear <= 1'b0;
        end else begin
            state <= next_state;
            keepClear <= next_keepClear;
        end
    end

    // ************************************************************
    // Status and outputs
    // ************************************************************
    assign statusClear = clearFaults || runRise || biasFall;

    // Hardware set wins over any clear arriving in the same cycle
    always_comb begin
        next_faultStatus = faultStatus;
        if (statusClear) begin
            next_faultStatus = '0;
        end
        if (ovFault) begin
            next_faultStatus.statusByteOv = 1'b1;
            next_faultStatus.statusWordVout = 1'b1;
            next_faultStatus.statusVoutOv = 1'b1;
        end
        if (uvFault) begin
            next_faultStatus.statusWordVout = 1'b1;
            next_faultStatus.statusVoutUv = 1'b1;
        end
        if (cfgWrite && !respValid(cfgSelUv, cfgData)) begin
            next_faultStatus.cmlFault = 1'b1;
        end
    end

    // Rail drive, low-side pull-down and alert line
    always_comb begin
        next_outputEnable = (next_state == ST_RUN);
        next_pullDownActive = ovFault && ((respField(ovResponse) == RESP_IGNORE) ||
                              (next_state != ST_RUN));
        next_alertN = !((next_faultStatus.statusVoutOv && !alertMaskOv) ||
                        (next_faultStatus.statusVoutUv && !alertMaskUv) ||
                        next_faultStatus.cmlFault);
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            faultStatus <= '0;
            outputEnable <= 1'b0;
            pullDownActive <= 1'b0;
            alertN <= 1'b1;
        end else begin
            faultStatus <= next_faultStatus;
            outputEnable <= next_outputEnable;
            pullDownActive <= next_pullDownActive;
            alertN <= next_alertN;
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    sequence s_ov_deglitch_start;
        $rose(ovFault) && outputEnable && state == ST_RUN && !goOff &&
        respField(ovResponse) == RESP_CONTINUE && delayOf(ovResponse) != '0;
    endsequence
    sequence s_rail_stays_on;
        outputEnable [*8];
    endsequence
    a_ov_status_set: assert property (ovFault |=> faultStatus.statusByteOv &&
        faultStatus.statusVoutOv && faultStatus.statusWordVout && (alertMaskOv || !alertN))
        else $error("overvoltage status or alert not raised");
    a_bad_write_cml: assert property (cfgWrite && !cfgSelUv && !respValid(1'b0, cfgData)
        |=> faultStatus.cmlFault && ovResponse == $past(ovResponse))
        else $error("refused overvoltage write changed state or missed CML");
    a_latch_holds: assert property (state == ST_LATCHED && !goOff &&
        !(clearFaults && keepClear) |=> !outputEnable && state == ST_LATCHED)
        else $error("latched rail restarted without release");
    a_retry_restart: assert property (state == ST_RETRY && retryDone && !goOff &&
        !ovLatchesDuringRetry |=> outputEnable)
        else $error("retry did not restart the rail");
    a_deglitch_wait: assert property (s_ov_deglitch_start |-> ##1 s_rail_stays_on)
        else $error("rail dropped before overvoltage hold time");
    a_immediate_off: assert property (state == ST_RUN && ovFault &&
        respField(ovResponse) == RESP_SHUT |=> !outputEnable)
        else $error("immediate shutdown did not disable rail");
    a_pull_down: assert property (ovFault && respField(ovResponse) == RESP_IGNORE
        |=> pullDownActive)
        else $error("pull-down not applied during overvoltage");
    a_pull_down_shut: assert property (ovFault ##1 !outputEnable |-> pullDownActive)
        else $error("pull-down not applied while the rail is off in overvoltage");
    a_pull_down_release: assert property (!ovFault |=> !pullDownActive)
        else $error("pull-down left on without overvoltage");
    a_uv_inactive: assert property (!outputEnable && !faultStatus.statusVoutUv
        |=> !faultStatus.statusVoutUv)
        else $error("undervoltage recorded while channel inactive");
    a_status_sticky: assert property (faultStatus.statusVoutUv && !statusClear
        |=> faultStatus.statusVoutUv)
        else $error("undervoltage bit cleared without a clear event");
    a_uv_ignore: assert property (state == ST_RUN && !goOff && !ovTrip && uvFault &&
        respField(uvResponse) == RESP_IGNORE |=> outputEnable)
        else $error("ignored undervoltage disabled the rail");

endmodule : vout_fault_response_logic

//--- inc/vout_fault_pkg.sv
// Constants, field layouts and carrier types for the output-rail fault response logic.
// Assumes a single 50 MHz clock; the fault logic, hold_timer and the bench import the whole package.
package vout_fault_pkg;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLK_MHZ = 50;                        // mclk rate in MHz
    localparam int TICK_US = 10;                        // Delay unit in microseconds
    localparam int TICK_CYCLES = TICK_US * CLK_MHZ;     // Cycles per delay unit
    localparam int PRESCALE_W = 9;
    localparam logic [PRESCALE_W-1:0] PRESCALE_LAST = PRESCALE_W'(TICK_CYCLES - 1);
    localparam int DELAY_W = 3;                         // Deglitch delay field width
    localparam int RETRY_W = 16;                        // Retry interval width, in delay units

    // ************************************************************
    // Response byte layout
    // ************************************************************
    localparam int RESP_MSB = 7;
    localparam int RESP_LSB = 6;
    localparam int RETRY_MSB = 5;
    localparam int RETRY_LSB = 3;
    localparam int DELAY_MSB = 2;
    localparam int DELAY_LSB = 0;
    localparam logic [1:0] RESP_IGNORE = 2'h0;          // Overvoltage: pull down only
    localparam logic [1:0] RESP_CONTINUE = 2'h1;        // Run on for the delay, then act
    localparam logic [1:0] RESP_SHUT = 2'h2;            // Disable at once
    localparam logic [1:0] RESP_BAD = 2'h3;             // Unsupported
    localparam logic [2:0] RETRY_FOREVER = 3'h7;

    // Overvoltage byte: the only accepted codes
    localparam logic [7:0] OV_CODE_LATCH = 8'h80;
    localparam logic [7:0] OV_CODE_RETRY = 8'hb8;
    localparam logic [4:0] OV_DEG_LATCH_TOP = 5'h08;    // 0x40..0x47
    localparam logic [4:0] OV_DEG_RETRY_TOP = 5'h0f;    // 0x78..0x7f

    // Reset values of the two response bytes
    localparam logic [7:0] OV_RESP_RESET = 8'h7a;
    localparam logic [7:0] UV_RESP_RESET = 8'hb8;

    // ************************************************************
    // Carriers
    // ************************************************************
    typedef struct packed {
        logic tonDelayDone;
        logic tonRiseDone;
        logic tonMaxReached;
        logic uvLevelReached;
        logic toffFalling;
    } seq_status_s;

    typedef struct packed {
        logic statusByteOv;
        logic statusWordVout;
        logic statusVoutOv;
        logic statusVoutUv;
        logic cmlFault;
    } fault_status_s;

    // ************************************************************
    // Response byte decoding
    // ************************************************************
    function automatic logic [1:0] respField(input logic [7:0] code);
        respField = code[RESP_MSB:RESP_LSB];
    endfunction : respField

    function automatic logic retriesForever(input logic [7:0] code);
        retriesForever = (code[RETRY_MSB:RETRY_LSB] == RETRY_FOREVER);
    endfunction : retriesForever

    function automatic logic [DELAY_W-1:0] delayOf(input logic [7:0] code);
        delayOf = code[DELAY_MSB:DELAY_LSB];
    endfunction : delayOf

    function automatic logic respValid(input logic isUv, input logic [7:0] code);
        if (isUv) begin
            respValid = (respField(code) != RESP_BAD);
        end else begin
            respValid = (code == OV_CODE_LATCH) || (code == OV_CODE_RETRY) ||
                        (code[7:3] == OV_DEG_LATCH_TOP) || (code[7:3] == OV_DEG_RETRY_TOP);
        end
    endfunction : respValid

endpackage : vout_fault_pkg

//--- logic/pin_sync.sv
// Three-stage synchroniser for a group of pin inputs.
// Assumes the pins are asynchronous to mclk; output follows once stages two and three agree.
module pin_sync #(
    parameter int WIDTH = 1
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [WIDTH-1:0] pins,
    output logic [WIDTH-1:0] synced
);

    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;
    logic [WIDTH-1:0] next_synced;

    // Agreement filter per bit; the first stage feeds only the second
    always_comb begin
        for (int i = 0; i < WIDTH; i++) begin
            next_synced[i] = (stage2[i] == stage3[i]) ? stage3[i] : synced[i];
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            meta <= '0;
            stage2 <= '0;
            stage3 <= '0;
            synced <= '0;
        end else begin
            meta <= pins;
            stage2 <= meta;
            stage3 <= stage2;
            synced <= next_synced;
        end
    end

endmodule : pin_sync

//--- logic/hold_timer.sv
// Counts delay-unit ticks while a condition holds; restarts from zero when it drops.
// Assumes tick is a one-cycle enable on mclk; done is combinational from the count.
module hold_timer
    import vout_fault_pkg::*;
#(
    parameter int W = 3
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic tick,
    input wire logic run,
    input wire logic [W-1:0] target,
    output logic done
);

    // One bit wider than the target so a count past the largest target still fits
    logic [W:0] count;
    logic [W:0] next_count;

    // Saturating count so a long hold never wraps back below the target
    always_comb begin
        next_count = count;
        if (!run) begin
            next_count = '0;
        end else if (tick && (count != {(W+1){1'b1}})) begin
            next_count = count + (W+1)'(1);
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            count <= '0;
        end else begin
            count <= next_count;
        end
    end

    // The first tick comes at any phase, so one tick past the target guarantees the full hold
    assign done = run && ((target == '0) || (count > {1'b0, target}));

endmodule : hold_timer

//--- testbench/rail_partner.sv
// Behavioural model of the rail comparators that face the fault logic.
// Assumes the bench sets the overvoltage level; decay follows the enable.
module rail_partner #(
    parameter int DECAY_CYCLES = 1600
) (
    input wire logic mclk,
    input wire logic railOn,
    input wire logic ovLevel,
    output logic ovDetect,
    output logic decayBelowEighth
);
    timeunit 1ns;
    timeprecision 1ns;
    int offCount = 0;
    // Decay is slow on purpose, so it outlasts the programmed retry interval
    always @(posedge mclk) begin
        offCount <= railOn ? 0 : offCount + 1;
    end
    assign decayBelowEighth = (offCount > DECAY_CYCLES);
    assign ovDetect = ovLevel;
endmodule : rail_partner

//--- testbench/vout_fault_response_logic_test.sv
// Self-checking bench for the rail fault response logic.
// Assumes rail_partner models the comparators; inputs move 1 ns after mclk rises.
module vout_fault_response_logic_test;
    import vout_fault_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk = 0, sys_rst = 1, cfgWrite = 0, cfgSelUv = 0, clearFaults = 0, operationOn = 0;
    logic runPin = 0, softResetCmd = 0, uvDetect = 0, ocFault = 0, noDecayWait = 0;
    logic alertMaskOv = 0, alertMaskUv = 0, ovLevel = 0, ovDetect, decay, outputEnable, alertN, pullDown;
    logic [7:0] cfgData = 8'h00, ovResponse, uvResponse;
    fault_status_s faultStatus;
    seq_status_s seq = 5'h1e;
    int errors = 0, check_count = 0, n;
    always #10 mclk = ~mclk;
    vout_fault_response_logic u_dut (.mclk, .sys_rst, .cfgWrite, .cfgSelUv, .cfgData, .clearFaults,
        .softResetCmd, .operationOn, .channel_run_pin(runPin), .bias_input_supply(runPin), .ovDetect,
        .uvDetect, .decayBelowEighth(decay), .ocFault, .seq, .vendor_retry_interval_cmd(16'h0002),
        .noDecayWait, .alertMaskOv, .alertMaskUv, .outputEnable, .pullDownActive(pullDown), .faultStatus,
        .alertN, .ovResponse, .uvResponse);
    rail_partner u_rail (.mclk, .railOn(outputEnable), .ovLevel, .ovDetect, .decayBelowEighth(decay));
    // ****************
    // Shared tasks
    // ****************
    task chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task tick(input int k);
        repeat (k) @(posedge mclk);
        #1;
    endtask : tick
    // Extra cycle at the end keeps back-to-back writes from double-driving the strobe
    task wr(input logic uv, input logic [7:0] d);
        cfgWrite = 1;
        cfgSelUv = uv;
        cfgData = d;
        tick(1);
        cfgWrite = 0;
        tick(1);
    endtask : wr
    task clr;
        clearFaults = 1;
        tick(1);
        clearFaults = 0;
        tick(1);
    endtask : clr
    task waitEn(input logic v, input int lim);
        n = 0;
        while (outputEnable !== v && n < lim) begin
            tick(1);
            n++;
        end
        chk("outputEnable", outputEnable, v);
    endtask : waitEn
    task ovPulse(input int k);
        ovLevel = 1;
        tick(k);
        ovLevel = 0;
        tick(10);
    endtask : ovPulse
    // ****************
    // Scenarios
    // ****************
    task codesTest;
        logic [7:0] good [6] = '{8'h80, 8'hb8, 8'h40, 8'h47, 8'h78, 8'h7f};
        logic [7:0] bad [4] = '{8'h00, 8'h48, 8'h77, 8'hc0};
        foreach (good[i]) begin
            wr(0, good[i]);
            chk("ovResponse", ovResponse, good[i]);
        end
        foreach (bad[i]) begin
            wr(0, bad[i]);
            chk("ovResponse", ovResponse, 8'h7f);
            chk("cml alert", {faultStatus.cmlFault, alertN}, 2'b10);
            clr();
            chk("status", faultStatus, 5'h00);
        end
        wr(1, 8'hc2);
        chk("uvResponse", uvResponse, 8'hb8);
        chk("uv cml", faultStatus.cmlFault, 1);
        clr();
    endtask : codesTest
    task latchTest;
        wr(0, 8'h80);
        ovPulse(8);
        chk("status", {faultStatus, alertN}, 6'h38);
        chk("pullDown", pullDown, 0);
        waitEn(0, 1);
        tick(1500);
        waitEn(0, 1);
        clr();
        chk("status", faultStatus, 5'h00);
        waitEn(1, 20);
    endtask : latchTest
    // Both retry codes: immediate code first, then the deglitched code with no hold
    task retryTest;
        wr(0, 8'hb8);
        ovPulse(8);
        waitEn(0, 1);
        waitEn(1, 2500);
        chk("retry wait", n > 1500, 1);
        wr(0, 8'h78);
        ovPulse(8);
        waitEn(0, 1);
        waitEn(1, 2500);
        clr();
    endtask : retryTest
    task deglitchTest;
        wr(0, 8'h42);
        ovPulse(600);
        waitEn(1, 1);
        ovLevel = 1;
        tick(900);
        waitEn(1, 1);
        waitEn(0, 700);
        chk("pullDown", pullDown, 1);
        ovLevel = 0;
        clr();
        tick(100);
        waitEn(0, 1);
        operationOn = 0;
        tick(10);
        operationOn = 1;
        waitEn(1, 30);
        wr(0, 8'h40);
        alertMaskOv = 1;
        ovPulse(8);
        chk("masked ov", {faultStatus, alertN}, 6'h39);
        waitEn(0, 1);
        softResetCmd = 1;
        tick(1);
        softResetCmd = 0;
        waitEn(1, 10);
        alertMaskOv = 0;
    endtask : deglitchTest
    // Ignored undervoltage: status and alert only, rail keeps running
    task uvTest;
        clr();
        wr(1, 8'h00);
        alertMaskUv = 1;
        uvDetect = 1;
        tick(8);
        chk("uv status", {faultStatus, alertN}, 6'h15);
        chk("outputEnable", outputEnable, 1);
        alertMaskUv = 0;
        tick(1);
        chk("uv alert", alertN, 0);
        uvDetect = 0;
        tick(6);
        chk("uv sticky", faultStatus, 5'h0a);
        clr();
        chk("status", faultStatus, 5'h00);
    endtask : uvTest
    task results;
        $display("errors %0d checks %0d", errors, check_count);
        if (errors == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : results
    // Main sequence, then a watchdog well past the expected run length
    initial begin
        tick(3);
        sys_rst = 0;
        chk("ovResponse", ovResponse, 8'h7a);
        chk("idle", {outputEnable, alertN, faultStatus}, 7'h20);
        codesTest();
        runPin = 1;
        operationOn = 1;
        waitEn(1, 20);
        latchTest();
        retryTest();
        deglitchTest();
        uvTest();
        results();
    end
    initial begin
        #400us;
        errors++;
        results();
    end
endmodule : vout_fault_response_logic_test
